/* hw/rsc_consts.svh */
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH

// Special function register addresses
`define RSC_ADDR_SUPPLY      8'hff
`define RSC_ADDR_CAUSE       8'hef

// Supply monitor control fields
`define RSC_SUP_EN_BIT       7
`define RSC_SUP_RST_OK_BIT   6
`define RSC_SUP_WARN_OK_BIT  5
`define RSC_SUP_EWIE_BIT     3

// Reset cause register fields
`define RSC_CA_FLASH_BIT     6
`define RSC_CA_CMP_BIT       5
`define RSC_CA_WDT_BIT       3
`define RSC_CA_CLK_BIT       2
`define RSC_CA_POWER_BIT     1
`define RSC_CA_PIN_BIT       0

// Reset values
`define RSC_SUP_EN_RST       1'b1
`define RSC_SUP_EWIE_RST     1'b1
`define RSC_MON_SEL_RST      1'b1
`define RSC_CLK_EN_RST       1'b0
`define RSC_CMP_SEL_RST      1'b0

// Timing
`define RSC_CLK_PERIOD_NS    10
`define RSC_CLK_LOSS_US      100
`define RSC_CLK_LOSS_CYC     ((`RSC_CLK_LOSS_US * 1000) / `RSC_CLK_PERIOD_NS)
`define RSC_WDT_DIV          12
`define RSC_WDT_TIMEOUT      65535
`define RSC_HOLD_CYC         8

`endif

/* hw/rsc_pkg.sv */
package rsc_pkg;

    // Which source caused the last reset
    typedef enum logic [2:0] {
        RSC_CAUSE_POWER,
        RSC_CAUSE_PIN,
        RSC_CAUSE_SUPPLY,
        RSC_CAUSE_CLK,
        RSC_CAUSE_CMP,
        RSC_CAUSE_WDT,
        RSC_CAUSE_FLASH
    } rsc_cause_t;

    typedef enum logic {
        RSC_RUN,
        RSC_HOLD
    } rsc_state_t;

    // Special function register access from the core
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } rsc_sfr_req_t;

    // Flash access attempts reported by the flash controller
    typedef struct packed {
        logic write_erase;
        logic program_store_write_enable;
        logic write_above_lock;
        logic read_above_lock;
        logic fetch_above_lock;
        logic security_block;
    } rsc_flash_req_t;

endpackage : rsc_pkg

/* hw/rsc_watchdog.sv */
`include "rsc_consts.svh"

// Watchdog with a fixed divide-by prescaler
module rsc_watchdog
    import rsc_pkg::*;
#(
    parameter int DIV     = `RSC_WDT_DIV,
    parameter int CNT_W   = 16,
    parameter int TIMEOUT = `RSC_WDT_TIMEOUT
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic sys_rst,
    input  wire logic kick,
    input  wire logic disable_sw,
    input  wire logic suppress,
    output logic      running,
    output logic      expired
);
    localparam logic [3:0]       DIV_LAST = 4'(DIV - 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT - 1);

    logic [3:0]       pre_q;
    logic [CNT_W-1:0] cnt_q;
    logic             en_q;
    logic             exp_q;

    wire tick   = (pre_q == DIV_LAST);
    wire active = en_q && !suppress;
    wire hit    = active && tick && (cnt_q == CNT_LAST);

    assign running = en_q;
    assign expired = exp_q;

    // Prescaler restarts on every system reset so the divide ratio holds from any reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 4'h0;
        end else begin
            pre_q <= (tick || sys_rst) ? 4'h0 : pre_q + 4'h1;
        end
    end

    // Enabled after any reset; suspend only pauses, enable is kept
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            en_q  <= 1'b1;
            cnt_q <= '0;
            exp_q <= 1'b0;
        end else if (sys_rst) begin
            en_q  <= 1'b1;
            cnt_q <= '0;
            exp_q <= 1'b0;
        end else begin
            if (disable_sw) begin
                en_q <= 1'b0;
            end
            if (kick || disable_sw) begin
                cnt_q <= '0;
            end else if (active && tick) begin
                cnt_q <= cnt_q + CNT_W'(1);
            end
            exp_q <= hit && !kick;
        end
    end

endmodule : rsc_watchdog

/* hw/rsc_reset_source_controller.sv */
// Notes on behaviour
// - Monitor enable bit 7 switches monitor; reset only when also selected as source.
// - Bit 6 reads 1 above reset threshold, 0 at or below.
// - Bit 5 reads 1 above warning threshold, 0 at or below.
// - Bit 3 enables early warning interrupt; resets to 1.
// - Supply control bits 4 and 2:0 read zero; writes ignored.
// - Low level on reset pin holds device in reset while held.
// - Pin reset works in suspend and sleep too.
// - Leaving a pin reset sets pin flag, cause bit 0.
// - Enabled clock loss detector resets after clock stuck over 100 us.
// - Cause bit 2 reads clock loss flag; write enables detector.
// - Clock loss reset suppressed in low power; enable kept for exit.
// - Internal sources never drive the reset pin.
// - Cause bit 5 write selects comparator; reset while plus input below minus.
// - Comparator flag reads 1 only after comparator reset.
// - Comparator reset in low power only when it is a wake source.
// - After any reset watchdog enabled, clocked at system clock over 12.
// - Watchdog timeout resets the device and sets watchdog flag.
// - Watchdog reset suppressed in low power; enable kept for exit.
// - Flash write above lock, code read or fetch above lock resets.
// - Secured flash access or write with monitor off resets.
// - Flash error reset sets flash flag, cause bit 6.
// - With power flag set other flags are not meaningful.
// - Supply dropping below warning clears status and may interrupt.
`include "rsc_consts.svh"

module rsc_reset_source_controller
    import rsc_pkg::*;
#(
    parameter int CLK_LOSS_CYC = `RSC_CLK_LOSS_CYC,
    parameter int HOLD_CYC     = `RSC_HOLD_CYC,
    parameter int WDT_TIMEOUT  = `RSC_WDT_TIMEOUT
) (
    input  wire logic           mclk,
    input  wire logic           rst_n,
    input  wire rsc_sfr_req_t   sfr_req,
    output logic [7:0]          sfr_rdata,
    input  wire logic           rst_pin_n,
    input  wire logic           supply_above_reset_raw,
    input  wire logic           supply_above_warning_raw,
    input  wire logic           sys_clk_mon,
    input  wire logic           comparator_plus_below_raw,
    input  wire logic           cmp_wake_en,
    input  wire logic           low_power,
    input  wire logic           wdt_kick,
    input  wire logic           wdt_disable,
    input  wire rsc_flash_req_t flash_req,
    output logic                sys_rst_n,
    output logic                early_warning_irq,
    output logic                supply_monitor_on,
    output logic                wdt_running
);
    localparam int SYNC_N = 5;
    localparam int SY_PIN  = 0;
    localparam int SY_RST  = 1;
    localparam int SY_WARN = 2;
    localparam int SY_CLK  = 3;
    localparam int SY_CMP  = 4;
    localparam logic [15:0] LOSS_LAST = 16'(CLK_LOSS_CYC - 1);
    localparam logic [7:0]  HOLD_LAST = 8'(HOLD_CYC - 1);

    // Synchroniser stages
    logic [SYNC_N-1:0] raw_in;
    logic [SYNC_N-1:0] meta_q;
    logic [SYNC_N-1:0] sync_q;

    // Control registers
    logic supply_en_q;
    logic ewie_q;
    logic mon_sel_q;
    logic clk_en_q;
    logic cmp_sel_q;

    // Sequencer state
    rsc_state_t state_q;
    rsc_state_t state_d;
    rsc_cause_t cause_q;
    rsc_cause_t cause_d;
    logic [7:0]  hold_q;
    logic [15:0] loss_q;
    logic        clk_prev_q;
    logic        warn_prev_q;
    logic        irq_q;
    logic [7:0]  rdata_q;
    logic        wdt_expired;

    assign raw_in = {comparator_plus_below_raw, sys_clk_mon,
                     supply_above_warning_raw, supply_above_reset_raw, rst_pin_n};

    // Two flops per asynchronous input; only sync_q is read by logic
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end else begin
                    meta_q[gi] <= raw_in[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    wire pin_low    = !sync_q[SY_PIN];
    wire above_rst  = sync_q[SY_RST];
    wire above_warn = sync_q[SY_WARN];
    wire cmp_below  = sync_q[SY_CMP];
    wire in_reset   = (state_q == RSC_HOLD);

    // Register decode
    wire wr_supply = sfr_req.wr && !in_reset && (sfr_req.addr == `RSC_ADDR_SUPPLY);
    wire wr_cause  = sfr_req.wr && !in_reset && (sfr_req.addr == `RSC_ADDR_CAUSE);
    wire rd_supply = sfr_req.addr == `RSC_ADDR_SUPPLY;
    wire rd_cause  = sfr_req.addr == `RSC_ADDR_CAUSE;

    // Clock loss: stuck level on the monitored clock for the full window
    wire clk_moved = sync_q[SY_CLK] != clk_prev_q;
    wire clk_armed = clk_en_q && !low_power && !in_reset;
    wire loss_src  = clk_armed && (loss_q == LOSS_LAST);

    // Supply level source holds the reset for as long as it persists; cmp_src drops once in_reset clears cmp_sel_q; wdt_src is a one-cycle pulse
    wire supply_src = supply_en_q && mon_sel_q && !above_rst;
    wire cmp_src    = cmp_sel_q && cmp_below
                      && (!low_power || cmp_wake_en);
    wire wdt_src    = wdt_expired;

    // Flash access faults
    wire fl_write   = flash_req.write_erase && flash_req.program_store_write_enable;
    wire flash_src  = (fl_write && flash_req.write_above_lock)
                      || flash_req.read_above_lock
                      || flash_req.fetch_above_lock;
    wire flash_src2 = flash_req.security_block
                      || (fl_write && !supply_en_q);
    wire flash_any  = flash_src || flash_src2;

    // Pin stays live in every power mode
    wire level_src = pin_low || supply_src || cmp_src;
    wire any_src   = level_src || loss_src || wdt_src || flash_any;

    // One cause, highest priority first
    always_comb begin
        cause_d = cause_q;
        if (pin_low) begin
            cause_d = RSC_CAUSE_PIN;
        end else if (supply_src) begin
            cause_d = RSC_CAUSE_SUPPLY;
        end else if (loss_src) begin
            cause_d = RSC_CAUSE_CLK;
        end else if (cmp_src) begin
            cause_d = RSC_CAUSE_CMP;
        end else if (wdt_src) begin
            cause_d = RSC_CAUSE_WDT;
        end else if (flash_any) begin
            cause_d = RSC_CAUSE_FLASH;
        end
    end

    // Hold at least HOLD_CYC cycles, longer while a level source persists
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            RSC_RUN: begin
                if (any_src) begin
                    state_d = RSC_HOLD;
                end
            end
            RSC_HOLD: begin
                if (!level_src && hold_q >= HOLD_LAST) begin
                    state_d = RSC_RUN;
                end
            end
        endcase
    end

    // Sequencer; power-on comes up in hold with the power cause
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= RSC_HOLD;
            cause_q <= RSC_CAUSE_POWER;
            hold_q  <= 8'h00;
        end else begin
            state_q <= state_d;
            if (!in_reset && any_src) begin
                cause_q <= cause_d;
                hold_q  <= 8'h00;
            end else if (in_reset && hold_q != 8'hff) begin
                hold_q <= hold_q + 8'h01;
            end
        end
    end

    // Internal reset only; the pin is an input and never driven
    assign sys_rst_n = !in_reset;

    // Clock loss counter restarts on every edge of the monitored clock
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev_q <= 1'b0;
            loss_q     <= 16'h0000;
        end else begin
            clk_prev_q <= sync_q[SY_CLK];
            if (clk_moved || !clk_armed) begin
                loss_q <= 16'h0000;
            end else if (loss_q != LOSS_LAST) begin
                loss_q <= loss_q + 16'h0001;
            end
        end
    end

    // Supply monitor settings return to reset values only on power reset, not system reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            supply_en_q <= `RSC_SUP_EN_RST;
            ewie_q      <= `RSC_SUP_EWIE_RST;
            mon_sel_q   <= `RSC_MON_SEL_RST;
        end else begin
            if (wr_supply) begin
                supply_en_q <= sfr_req.wdata[`RSC_SUP_EN_BIT];
                ewie_q      <= sfr_req.wdata[`RSC_SUP_EWIE_BIT];
            end
            if (wr_cause) begin
                mon_sel_q <= sfr_req.wdata[`RSC_CA_POWER_BIT];
            end
        end
    end

    // Detector and comparator selects restart cleared after any reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clk_en_q  <= `RSC_CLK_EN_RST;
            cmp_sel_q <= `RSC_CMP_SEL_RST;
        end else if (in_reset) begin
            clk_en_q  <= `RSC_CLK_EN_RST;
            cmp_sel_q <= `RSC_CMP_SEL_RST;
        end else if (wr_cause) begin
            clk_en_q  <= sfr_req.wdata[`RSC_CA_CLK_BIT];
            cmp_sel_q <= sfr_req.wdata[`RSC_CA_CMP_BIT];
        end
    end

    // Cause flags are decoded from the one latched cause
    wire [7:0] cause_rd;
    assign cause_rd[7] = 1'b0;
    assign cause_rd[`RSC_CA_FLASH_BIT] = (cause_q == RSC_CAUSE_FLASH);
    assign cause_rd[`RSC_CA_CMP_BIT]   = (cause_q == RSC_CAUSE_CMP);
    assign cause_rd[4] = 1'b0;
    assign cause_rd[`RSC_CA_WDT_BIT]   = (cause_q == RSC_CAUSE_WDT);
    assign cause_rd[`RSC_CA_CLK_BIT]   = (cause_q == RSC_CAUSE_CLK);
    assign cause_rd[`RSC_CA_POWER_BIT] = (cause_q == RSC_CAUSE_POWER)
                                         || (cause_q == RSC_CAUSE_SUPPLY);
    assign cause_rd[`RSC_CA_PIN_BIT]   = (cause_q == RSC_CAUSE_PIN);

    // Unused supply bits are constant zero
    wire [7:0] supply_rd = {supply_en_q, above_rst, above_warn, 1'b0,
                            ewie_q, 3'b000};

    wire [7:0] rd_mux = rd_supply ? supply_rd :
                        rd_cause  ? cause_rd  : 8'h00;

    // Read data registered; unmapped addresses return zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (sfr_req.rd) begin
            rdata_q <= rd_mux;
        end
    end

    // Early warning: one pulse on the falling edge of the status
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            warn_prev_q <= 1'b0;
            irq_q       <= 1'b0;
        end else begin
            warn_prev_q <= above_warn;
            irq_q       <= warn_prev_q && !above_warn && ewie_q;
        end
    end

    assign sfr_rdata         = rdata_q;
    assign early_warning_irq = irq_q;
    assign supply_monitor_on = supply_en_q;

    // Watchdog restarts enabled on every reset; paused in low power
    rsc_watchdog #(
        .DIV     (`RSC_WDT_DIV),
        .CNT_W   (16),
        .TIMEOUT (WDT_TIMEOUT)
    ) u_rsc_watchdog (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .sys_rst    (in_reset),
        .kick       (wdt_kick),
        .disable_sw (wdt_disable),
        .suppress   (low_power),
        .running    (wdt_running),
        .expired    (wdt_expired)
    );

endmodule : rsc_reset_source_controller

/* tb/rsc_reset_source_controller_assertions.sv */
// Port-level checks of the reset source controller
module rsc_reset_source_controller_assertions
    import rsc_pkg::*;
(
    input wire logic           mclk,
    input wire logic           rst_n,
    input wire rsc_sfr_req_t   sfr_req,
    input wire logic [7:0]     sfr_rdata,
    input wire logic           rst_pin_n,
    input wire logic           supply_above_reset_raw,
    input wire logic           supply_above_warning_raw,
    input wire logic           low_power,
    input wire rsc_flash_req_t flash_req,
    input wire logic           sys_rst_n,
    input wire logic           early_warning_irq,
    input wire logic           supply_monitor_on,
    input wire logic           wdt_running
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Register reads decoded once
    wire sup_rd   = sfr_req.rd && sfr_req.addr == 8'hff;
    wire cause_rd = sfr_req.rd && sfr_req.addr == 8'hef;

    // Four edges cover the pin synchroniser plus the answer cycle
    property p_pin_hold; !rst_pin_n [*4] |-> !sys_rst_n; endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin low, system running");
    property p_pin_sleep; (low_power && !rst_pin_n) [*4] |-> !sys_rst_n; endproperty
    a_pin_sleep: assert property (p_pin_sleep) else $error("pin reset lost in sleep");
    property p_min_low; $fell(sys_rst_n) |-> !sys_rst_n [*8]; endproperty
    a_min_low: assert property (p_min_low) else $error("reset pulse too short");
    property p_unused; sup_rd |=> sfr_rdata[4] == 1'b0 && sfr_rdata[2:0] == 3'h0; endproperty
    a_unused: assert property (p_unused) else $error("unused supply bits set");
    // Level must be steady long enough to have crossed the synchroniser
    property p_rst_lvl;
        sup_rd && supply_above_reset_raw == $past(supply_above_reset_raw, 2)
        && supply_above_reset_raw == $past(supply_above_reset_raw)
        |=> sfr_rdata[6] == $past(supply_above_reset_raw);
    endproperty
    a_rst_lvl: assert property (p_rst_lvl) else $error("reset level bit wrong");
    property p_irq_pulse; early_warning_irq |=> !early_warning_irq; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("warning irq too long");
    property p_irq_cause;
        early_warning_irq |-> !$past(supply_above_warning_raw, 2)
        || !$past(supply_above_warning_raw, 3) || !$past(supply_above_warning_raw, 4);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without warning");
    property p_wdt_on; $rose(sys_rst_n) |-> wdt_running; endproperty
    a_wdt_on: assert property (p_wdt_on) else $error("watchdog off after reset");
    property p_flash_addr;
        sys_rst_n && (flash_req.read_above_lock || flash_req.fetch_above_lock
        || flash_req.write_erase && flash_req.program_store_write_enable
        && flash_req.write_above_lock) |=> !sys_rst_n;
    endproperty
    a_flash_addr: assert property (p_flash_addr) else $error("no flash reset");
    property p_flash_sec;
        sys_rst_n && (flash_req.security_block || flash_req.write_erase
        && flash_req.program_store_write_enable && !supply_monitor_on)
        |=> !sys_rst_n;
    endproperty
    a_flash_sec: assert property (p_flash_sec) else $error("no flash fault reset");
    property p_one_cause; cause_rd |=> $onehot(sfr_rdata); endproperty
    a_one_cause: assert property (p_one_cause) else $error("cause not one flag");

    c_reset: cover property ($fell(sys_rst_n));
    c_irq: cover property (early_warning_irq);
    c_flash: cover property (cause_rd ##1 sfr_rdata == 8'h40);
endmodule : rsc_reset_source_controller_assertions

/* tb/rsc_far_side.sv */
// Reset pin, supply comparators, comparator and monitored clock
module rsc_far_side (
    input wire logic  mclk,
    input wire logic  pin_req,
    input wire logic  [1:0] supply_lvl,
    input wire logic  cmp_low,
    input wire logic  clk_stop,
    output logic      rst_pin_n,
    output logic      supply_above_reset_raw,
    output logic      supply_above_warning_raw,
    output logic      comparator_plus_below_raw,
    output logic      sys_clk_mon
);
    timeunit 1ns;
    timeprecision 1ps;
    // Open drain with pull-up: released pin reads high
    assign rst_pin_n = !pin_req;
    // Level 2 above both thresholds, 1 above reset only, 0 below both
    assign supply_above_reset_raw   = supply_lvl != 2'h0;
    assign supply_above_warning_raw = supply_lvl == 2'h2;
    assign comparator_plus_below_raw = cmp_low;
    // Stopped clock freezes at its last level
    initial sys_clk_mon = 1'b0;
    always @(negedge mclk) if (!clk_stop) sys_clk_mon <= ~sys_clk_mon;
endmodule : rsc_far_side

/* tb/tb_reset_source_controller.sv */
module tb_reset_source_controller
    import rsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic           mclk = 1'b0, rst_n = 1'b0, cmp_wake_en = 1'b0, low_power = 1'b0;
    logic           wdt_kick = 1'b0, pin_req = 1'b0, cmp_low = 1'b0, clk_stop = 1'b0;
    logic           kick_on = 1'b1, rd_q = 1'b0, bad;
    logic [1:0]     supply_lvl = 2'h2;
    logic [3:0]     cyc = 4'h0;
    logic [7:0]     sfr_rdata, d;
    logic [7:0]     exp_q[$];
    logic [5:0]     ftbl[5] = '{6'h38, 6'h04, 6'h02, 6'h01, 6'h30};
    rsc_sfr_req_t   sfr_req = '0;
    rsc_flash_req_t flash_req = '0;
    logic           rst_pin_n, supply_above_reset_raw, supply_above_warning_raw;
    logic           comparator_plus_below_raw, sys_clk_mon, sys_rst_n;
    logic           early_warning_irq, supply_monitor_on, wdt_running;
    int             mismatches = 0, checks_done = 0, irq_cnt = 0, seed = 9;

    always #5 mclk = ~mclk;

    rsc_reset_source_controller #(.CLK_LOSS_CYC(20), .HOLD_CYC(8), .WDT_TIMEOUT(4))
    u_rsc_reset_source_controller (
        .mclk(mclk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .rst_pin_n(rst_pin_n), .supply_above_reset_raw(supply_above_reset_raw),
        .supply_above_warning_raw(supply_above_warning_raw), .sys_clk_mon(sys_clk_mon),
        .comparator_plus_below_raw(comparator_plus_below_raw), .cmp_wake_en(cmp_wake_en),
        .low_power(low_power), .wdt_kick(wdt_kick), .wdt_disable(1'b0),
        .flash_req(flash_req), .sys_rst_n(sys_rst_n), .early_warning_irq(early_warning_irq),
        .supply_monitor_on(supply_monitor_on), .wdt_running(wdt_running)
    );
    rsc_far_side u_rsc_far_side (
        .mclk(mclk), .pin_req(pin_req), .supply_lvl(supply_lvl), .cmp_low(cmp_low),
        .clk_stop(clk_stop), .rst_pin_n(rst_pin_n),
        .supply_above_reset_raw(supply_above_reset_raw),
        .supply_above_warning_raw(supply_above_warning_raw),
        .comparator_plus_below_raw(comparator_plus_below_raw), .sys_clk_mon(sys_clk_mon)
    );

    // Kick well inside the watchdog window unless a test starves it
    always @(negedge mclk) begin
        cyc <= cyc + 4'h1;
        wdt_kick <= kick_on && cyc == 4'h0;
    end
    // Read data lands one edge after the strobe
    always @(posedge mclk) rd_q <= sfr_req.rd;
    always @(negedge mclk) begin
        if (rd_q) chk(sfr_rdata, exp_q.pop_front());
        if (early_warning_irq === 1'b1) irq_cnt++;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge mclk) sfr_req = '{a, 1'b1, 1'b0, v};
        @(negedge mclk) sfr_req.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk) sfr_req = '{a, 1'b0, 1'b1, 8'h00};
        exp_q.push_back(e);
        @(negedge mclk) sfr_req.rd = 1'b0;
    endtask : rd
    // Bounded wait for the system reset to reach a level
    task automatic wait_rst(input logic lvl, input int lim);
        int n = 0;
        while (sys_rst_n !== lvl && n < lim) begin
            @(negedge mclk);
            n++;
        end
        chk({7'h0, sys_rst_n}, {7'h0, lvl});
        if (n >= lim) print_verdict();
    endtask : wait_rst
    task automatic quiet(input int n);
        bad = 1'b0;
        repeat (n) @(negedge mclk) if (sys_rst_n !== 1'b1) bad = 1'b1;
        chk({7'h0, bad}, 8'h00);
    endtask : quiet
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : wait_cyc

    initial begin
        wait_cyc(3);
        rst_n = 1'b1;
        wait_rst(1'b1, 40);
        rd(8'hef, 8'h02);
        rd(8'hff, 8'he8);
        wr(8'hff, 8'h17);
        rd(8'hff, 8'h60);
        chk({7'h0, supply_monitor_on}, 8'h00);
        wr(8'hff, 8'h88);
        supply_lvl = 2'h1;
        wait_cyc(8);
        rd(8'hff, 8'hc8);
        chk(irq_cnt[7:0], 8'h01);
        wr(8'hff, 8'h80);
        supply_lvl = 2'h2;
        wait_cyc(8);
        supply_lvl = 2'h1;
        wait_cyc(8);
        chk(irq_cnt[7:0], 8'h01);
        // Monitor off and deselected: a supply drop must not reset
        wr(8'hff, 8'h00);
        wr(8'hef, 8'h00);
        supply_lvl = 2'h0;
        quiet(20);
        rd(8'hff, 8'h00);
        supply_lvl = 2'h2;
        wr(8'hff, 8'h88);
        wr(8'hef, 8'h02);
        supply_lvl = 2'h0;
        wait_rst(1'b0, 20);
        rd(8'hff, 8'h88);
        supply_lvl = 2'h2;
        wait_rst(1'b1, 40);
        rd(8'hef, 8'h02);
        $display("test supply register done");
        low_power = 1'b1;
        pin_req = 1'b1;
        wait_rst(1'b0, 10);
        wait_cyc(30);
        chk({7'h0, sys_rst_n}, 8'h00);
        pin_req = 1'b0;
        low_power = 1'b0;
        wait_rst(1'b1, 40);
        rd(8'hef, 8'h01);
        $display("test pin reset done");
        wr(8'hef, 8'h06);
        clk_stop = 1'b1;
        wait_rst(1'b0, 60);
        clk_stop = 1'b0;
        wait_rst(1'b1, 40);
        rd(8'hef, 8'h04);
        wr(8'hef, 8'h06);
        low_power = 1'b1;
        clk_stop = 1'b1;
        quiet(60);
        low_power = 1'b0;
        wait_rst(1'b0, 60);
        clk_stop = 1'b0;
        wait_rst(1'b1, 40);
        rd(8'hef, 8'h04);
        $display("test clock loss done");
        cmp_low = 1'b1;
        quiet(20);
        // Comparator settled high before it is selected
        cmp_low = 1'b0;
        wait_cyc(4);
        wr(8'hef, 8'h22);
        cmp_low = 1'b1;
        wait_rst(1'b0, 20);
        cmp_low = 1'b0;
        wait_rst(1'b1, 40);
        rd(8'hef, 8'h20);
        wr(8'hef, 8'h22);
        low_power = 1'b1;
        cmp_low = 1'b1;
        quiet(20);
        cmp_wake_en = 1'b1;
        wait_rst(1'b0, 20);
        cmp_low = 1'b0;
        low_power = 1'b0;
        cmp_wake_en = 1'b0;
        wait_rst(1'b1, 40);
        rd(8'hef, 8'h20);
        $display("test comparator done");
        kick_on = 1'b0;
        low_power = 1'b1;
        quiet(100);
        low_power = 1'b0;
        wait_rst(1'b0, 80);
        kick_on = 1'b1;
        wait_rst(1'b1, 40);
        rd(8'hef, 8'h08);
        chk({7'h0, wdt_running}, 8'h01);
        $display("test watchdog done");
        for (int i = 0; i < 5; i++) begin
            if (i == 4) wr(8'hff, 8'h08);
            flash_req = ftbl[i];
            wait_rst(1'b0, 10);
            flash_req = '0;
            wait_rst(1'b1, 40);
            rd(8'hef, 8'h40);
        end
        $display("test flash fault done");
        repeat (8) begin
            d = 8'($random(seed));
            wr(8'hff, d);
            rd(8'hff, {d[7], 2'b11, 1'b0, d[3], 3'h0});
        end
        $display("test random writes done");
        print_verdict();
    end
endmodule : tb_reset_source_controller

bind rsc_reset_source_controller rsc_reset_source_controller_assertions u_chk (
    .mclk(mclk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .rst_pin_n(rst_pin_n), .supply_above_reset_raw(supply_above_reset_raw),
    .supply_above_warning_raw(supply_above_warning_raw), .low_power(low_power),
    .flash_req(flash_req), .sys_rst_n(sys_rst_n), .early_warning_irq(early_warning_irq),
    .supply_monitor_on(supply_monitor_on), .wdt_running(wdt_running)
);
